// >>> atu_pkg.sv
/*
 * constants, state codes and widths shared by the address translation unit
 * assumes 32-bit byte addresses and one 32-bit page table entry per page
 */
// Overview of operation
// - translate virtual to physical addresses in 4KB pages, one entry per page
// - entries live in external memory and are fetched only on demand
// - on-chip entry cache keeps a recency list, evicts its last slot; per cycle only the lowest hitting source's entry is refreshed
// - every request's page address is compared with every cached entry
// - hit address joins cached physical page with untranslated page offset
// - miss reads entry from memory, fills cache, then stalled access proceeds
// - seven request sources served in parallel, all may miss together
// - 3 bit counter counts pending misses, up per miss, down per service
// - normal and miss phases; miss phase ends only at counter zero
package atu_pkg;
	localparam int ADDR_W = 32;
	localparam int OFS_W = 12; // 4KB page offset
	localparam int VPN_W = ADDR_W - OFS_W;
	localparam int SRC_N = 7;
	localparam int SRC_W = 3;
	localparam int CNT_W = 3;
	localparam int ENTRIES = 8;
	localparam int PTE_IDX_SHIFT = 2; // entry index to byte offset
	localparam int PTE_PPN_LSB = 12; // physical page field in entry
	localparam logic [CNT_W-1:0] CNT_RST = 3'h0;

	typedef enum logic [1:0] {
		PH_NORMAL = 2'b01,
		PH_MISS = 2'b10
	} atu_phase_t;

	typedef enum logic [2:0] {
		FT_IDLE = 3'b001,
		FT_ISSUE = 3'b010,
		FT_WAIT = 3'b100
	} atu_fetch_st_t;
endpackage : atu_pkg

// >>> atu_fetch_if.sv
/*
 * bundle between the entry cache and the entry fetch engine
 * assumes both ends run on the same clock
 */
`timescale 1ns/1ns
interface atu_fetch_if;
	logic [atu_pkg::SRC_N-1:0] pend;
	logic [atu_pkg::SRC_N-1:0][atu_pkg::VPN_W-1:0] vpn;
	logic done;
	logic [atu_pkg::SRC_W-1:0] done_src;
	logic [atu_pkg::VPN_W-1:0] done_vpn;
	logic [atu_pkg::VPN_W-1:0] done_ppn;
	modport cache (output pend, output vpn, input done, input done_src,
		input done_vpn, input done_ppn);
	modport walker (input pend, input vpn, output done, output done_src,
		output done_vpn, output done_ppn);
endinterface : atu_fetch_if

// >>> atu_walker.sv
/*
 * entry fetch engine: reads one page table entry per pending miss
 * assumes memory accepts the held rd_valid with rd_ready and answers with rvalid
 */
`timescale 1ns/1ns
module atu_walker (
	input wire logic clk,
	input wire logic nrst,
	atu_fetch_if.walker fi,
	input wire logic [atu_pkg::ADDR_W-1:0] table_base,
	output logic mem_rd_valid,
	output logic [atu_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic mem_rd_rvalid,
	input wire logic [atu_pkg::ADDR_W-1:0] mem_rd_rdata
);
	localparam int PAD_W = atu_pkg::ADDR_W - atu_pkg::VPN_W
		- atu_pkg::PTE_IDX_SHIFT;

	atu_pkg::atu_fetch_st_t st_ff, nxt_st;
	logic [atu_pkg::SRC_W-1:0] src_ff, nxt_src;
	logic [atu_pkg::VPN_W-1:0] vpn_ff, nxt_vpn;
	logic [atu_pkg::VPN_W-1:0] ppn_ff, nxt_ppn;
	logic [atu_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic done_ff, nxt_done;
	logic [atu_pkg::SRC_N-1:0] cand;

	// pick lowest pending source; the one just finished still shows pending
	always_comb begin
		cand = fi.pend;
		if (done_ff) begin
			cand[src_ff] = 1'b0;
		end
		nxt_st = st_ff;
		nxt_src = src_ff;
		nxt_vpn = vpn_ff;
		nxt_ppn = ppn_ff;
		nxt_addr = addr_ff;
		nxt_done = 1'b0;
		unique case (st_ff)
			atu_pkg::FT_IDLE: begin
				for (int s = atu_pkg::SRC_N - 1; s >= 0; s--) begin
					if (cand[s]) begin
						nxt_src = atu_pkg::SRC_W'(s);
						nxt_vpn = fi.vpn[s];
						nxt_addr = table_base
							+ {{PAD_W{1'b0}}, fi.vpn[s], 2'h0};
					end
				end
				if (|cand) begin
					nxt_st = atu_pkg::FT_ISSUE;
				end
			end
			atu_pkg::FT_ISSUE: begin
				if (mem_rd_ready) begin
					nxt_st = atu_pkg::FT_WAIT;
				end
			end
			atu_pkg::FT_WAIT: begin
				if (mem_rd_rvalid) begin
					nxt_ppn = mem_rd_rdata[atu_pkg::ADDR_W-1:
						atu_pkg::PTE_PPN_LSB];
					nxt_done = 1'b1;
					nxt_st = atu_pkg::FT_IDLE;
				end
			end
			default: nxt_st = atu_pkg::FT_IDLE;
		endcase
		if (!nrst) begin
			nxt_st = atu_pkg::FT_IDLE;
			nxt_done = 1'b0;
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
		src_ff <= nxt_src;
		vpn_ff <= nxt_vpn;
		ppn_ff <= nxt_ppn;
		addr_ff <= nxt_addr;
		done_ff <= nxt_done;
	end

	assign mem_rd_valid = (st_ff == atu_pkg::FT_ISSUE);
	assign mem_rd_addr = addr_ff;
	assign fi.done = done_ff;
	assign fi.done_src = src_ff;
	assign fi.done_vpn = vpn_ff;
	assign fi.done_ppn = ppn_ff;
endmodule : atu_walker

// >>> atu_translation_cache.sv
/*
 * address translation unit: seven sources, fully associative entry cache
 * in recency order, demand fetch of missing entries, miss phase control
 * assumes each source holds its request until its resp_valid pulse
 */
`timescale 1ns/1ns
module atu_translation_cache #(
	parameter int SOURCES = atu_pkg::SRC_N,
	parameter int ENTRIES = atu_pkg::ENTRIES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [SOURCES-1:0] req_valid,
	input wire logic [SOURCES-1:0][atu_pkg::ADDR_W-1:0] req_vaddr,
	output logic [SOURCES-1:0] resp_valid,
	output logic [SOURCES-1:0][atu_pkg::ADDR_W-1:0] resp_paddr,
	input wire logic [atu_pkg::ADDR_W-1:0] table_base,
	output logic mem_rd_valid,
	output logic [atu_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic mem_rd_rvalid,
	input wire logic [atu_pkg::ADDR_W-1:0] mem_rd_rdata,
	output logic miss_phase,
	output logic [atu_pkg::CNT_W-1:0] miss_count
);
	localparam int EW = $clog2(ENTRIES);
	localparam int VW = atu_pkg::VPN_W;
	localparam int OW = atu_pkg::OFS_W;

	// walker and fetch bundle are sized for the fixed source count
	generate
		if (SOURCES != atu_pkg::SRC_N || ENTRIES < 2) begin : g_chk
			$error("atu_translation_cache: unsupported parameters");
		end
	endgenerate

	// one miss per source at most, so the counter must hold them all
	generate
		if (SOURCES > (1 << atu_pkg::CNT_W) - 1) begin : g_cnt_chk
			$error("atu_translation_cache: miss counter too narrow");
		end
	endgenerate

	atu_fetch_if fi ();

	logic [ENTRIES-1:0] vld_ff, nxt_vld;
	logic [ENTRIES-1:0][VW-1:0] vpn_ff, nxt_vpn;
	logic [ENTRIES-1:0][VW-1:0] ppn_ff, nxt_ppn;
	logic [SOURCES-1:0] pend_ff, nxt_pend;
	logic [SOURCES-1:0] rv_ff, nxt_rv;
	logic [SOURCES-1:0][atu_pkg::ADDR_W-1:0] pa_ff, nxt_pa;
	logic [atu_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	atu_pkg::atu_phase_t ph_ff, nxt_ph;

	logic [SOURCES-1:0] look, hit, new_miss;
	logic [SOURCES-1:0][EW-1:0] hidx;
	logic [SOURCES-1:0][VW-1:0] hppn;
	logic [SOURCES-1:0][VW-1:0] rvpn;
	logic in_normal;

	// lookups run only in the normal phase; a miss phase freezes them all
	assign in_normal = (ph_ff == atu_pkg::PH_NORMAL);

	// per source: parallel compare against all entries
	generate
		for (genvar s = 0; s < SOURCES; s++) begin : g_src
			logic h;
			logic [EW-1:0] hi;
			logic [VW-1:0] hp;
			always_comb begin
				h = 1'b0;
				hi = '0;
				hp = '0;
				for (int e = ENTRIES - 1; e >= 0; e--) begin
					if (vld_ff[e] && vpn_ff[e] == req_vaddr[s][atu_pkg::ADDR_W-1:OW]) begin
						h = 1'b1;
						hi = EW'(e);
						hp = ppn_ff[e];
					end
				end
			end
			assign rvpn[s] = req_vaddr[s][atu_pkg::ADDR_W-1:OW];
			// skip the cycle of its own answer: address not yet replaced
			assign look[s] = req_valid[s] && !pend_ff[s] && !rv_ff[s]
				&& in_normal;
			assign hit[s] = h;
			assign hidx[s] = hi;
			assign hppn[s] = hp;
			assign new_miss[s] = look[s] && !h;
		end
	endgenerate

	// answers, miss bookkeeping and phase
	always_comb begin
		logic [atu_pkg::CNT_W-1:0] inc;
		inc = '0;
		nxt_rv = '0;
		nxt_pa = pa_ff;
		for (int s = 0; s < SOURCES; s++) begin
			if (look[s] && hit[s]) begin
				nxt_rv[s] = 1'b1;
				nxt_pa[s] = {hppn[s], req_vaddr[s][OW-1:0]};
			end
			inc = inc + atu_pkg::CNT_W'(new_miss[s]);
		end
		// one pending bit per source: a miss is never lost
		nxt_pend = pend_ff | new_miss;
		if (fi.done) begin
			nxt_pend[fi.done_src] = 1'b0;
		end
		// a pending source is never looked up, so set and clear never collide
		nxt_cnt = cnt_ff + inc - atu_pkg::CNT_W'(fi.done);
		nxt_ph = ph_ff;
		unique case (ph_ff)
			atu_pkg::PH_NORMAL: begin
				if (|new_miss) begin
					nxt_ph = atu_pkg::PH_MISS;
				end
			end
			atu_pkg::PH_MISS: begin
				if (cnt_ff == '0) begin
					nxt_ph = atu_pkg::PH_NORMAL;
				end
			end
			default: nxt_ph = atu_pkg::PH_NORMAL;
		endcase
		if (!nrst) begin
			nxt_rv = '0;
			nxt_pa = '0;
			nxt_pend = '0;
			nxt_cnt = atu_pkg::CNT_RST;
			nxt_ph = atu_pkg::PH_NORMAL;
		end
	end

	// recency list: slot 0 newest; fill beats a hit refresh
	// fills land only in the miss phase, when no lookup runs, so a race with a hit never occurs
	always_comb begin
		logic use_it;
		logic [EW-1:0] k;
		logic [VW-1:0] nv, np;
		use_it = 1'b0;
		k = EW'(ENTRIES - 1);
		nv = '0;
		np = '0;
		if (fi.done) begin
			use_it = 1'b1;
			nv = fi.done_vpn;
			np = fi.done_ppn;
			for (int e = ENTRIES - 1; e >= 0; e--) begin
				if (vld_ff[e] && vpn_ff[e] == fi.done_vpn) begin
					k = EW'(e); // refill of a cached page: no duplicate
				end
			end
		end else begin
			for (int s = SOURCES - 1; s >= 0; s--) begin
				if (look[s] && hit[s]) begin
					use_it = 1'b1;
					k = hidx[s];
					nv = rvpn[s];
					np = hppn[s];
				end
			end
		end
		nxt_vld = vld_ff;
		nxt_vpn = vpn_ff;
		nxt_ppn = ppn_ff;
		if (use_it) begin
			for (int e = 1; e < ENTRIES; e++) begin
				if (EW'(e) <= k) begin
					nxt_vld[e] = vld_ff[e-1]; // least recent drops out
					nxt_vpn[e] = vpn_ff[e-1];
					nxt_ppn[e] = ppn_ff[e-1];
				end
			end
			nxt_vld[0] = 1'b1;
			nxt_vpn[0] = nv;
			nxt_ppn[0] = np;
		end
		if (!nrst) begin
			nxt_vld = '0;
			nxt_vpn = '0;
			nxt_ppn = '0;
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		vld_ff <= nxt_vld;
		vpn_ff <= nxt_vpn;
		ppn_ff <= nxt_ppn;
		pend_ff <= nxt_pend;
		rv_ff <= nxt_rv;
		pa_ff <= nxt_pa;
		cnt_ff <= nxt_cnt;
		ph_ff <= nxt_ph;
	end

	// pending pages go to the fetch engine
	assign fi.pend = pend_ff;
	generate
		for (genvar s = 0; s < SOURCES; s++) begin : g_vpn
			assign fi.vpn[s] = rvpn[s];
		end
	endgenerate

	atu_walker u_walker (
		.clk(clk),
		.nrst(nrst),
		.fi(fi),
		.table_base(table_base),
		.mem_rd_valid(mem_rd_valid),
		.mem_rd_addr(mem_rd_addr),
		.mem_rd_ready(mem_rd_ready),
		.mem_rd_rvalid(mem_rd_rvalid),
		.mem_rd_rdata(mem_rd_rdata)
	);

	assign resp_valid = rv_ff;
	assign resp_paddr = pa_ff;
	assign miss_phase = (ph_ff == atu_pkg::PH_MISS);
	assign miss_count = cnt_ff;
endmodule : atu_translation_cache

// >>> atu_mem_model.sv
/*
 * memory partner: answers page table entry reads, prompt or slow
 * assumes entry at base + vpn*4 holds {vpn ^ KEY, junk low bits}
 */
`timescale 1ns/1ns
module atu_mem_model #(
	parameter logic [19:0] KEY = 20'habcde
) (
	input wire logic clk,
	input wire logic slow,
	input wire logic [31:0] table_base,
	input wire logic mem_rd_valid,
	input wire logic [31:0] mem_rd_addr,
	output logic mem_rd_ready,
	output logic mem_rd_rvalid,
	output logic [31:0] mem_rd_rdata
);
	int wait_n = 0;
	logic busy = 1'b0;
	logic [19:0] vpn = '0;
	initial begin
		mem_rd_ready = 1'b0;
		mem_rd_rvalid = 1'b0;
		mem_rd_rdata = '0;
	end
	// data toggles when idle so a stale word never looks valid
	always @(posedge clk) begin
		mem_rd_rvalid <= 1'b0;
		mem_rd_rdata <= ~mem_rd_rdata;
		if (mem_rd_valid && mem_rd_ready) begin
			mem_rd_ready <= 1'b0;
			busy <= 1'b1;
			vpn <= 20'((mem_rd_addr - table_base) >> 2);
			wait_n <= slow ? 9 : 0;
		end else if (busy) begin
			if (wait_n == 0) begin
				busy <= 1'b0;
				mem_rd_rvalid <= 1'b1;
				mem_rd_rdata <= {vpn ^ KEY, 12'h5a5}; // low bits junk
				wait_n <= slow ? 4 : 0;
			end else begin
				wait_n <= wait_n - 1;
			end
		end else if (mem_rd_valid) begin
			if (wait_n == 0) mem_rd_ready <= 1'b1;
			else wait_n <= wait_n - 1;
		end
	end
endmodule : atu_mem_model

// >>> atu_cache_chk_sva.sv
/*
 * checker for the translation cache top ports
 * assumes one clock and synchronous active low reset
 */
`timescale 1ns/1ns
module atu_cache_chk #(
	parameter int SOURCES = 7,
	parameter int ENTRIES = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [SOURCES-1:0][31:0] req_vaddr,
	input wire logic [SOURCES-1:0] resp_valid,
	input wire logic [SOURCES-1:0][31:0] resp_paddr,
	input wire logic mem_rd_valid,
	input wire logic [31:0] mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic mem_rd_rvalid,
	input wire logic miss_phase,
	input wire logic [2:0] miss_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// answers and fetches tied to their causes
	ofs_keep_a: assert property (resp_valid[0] |->
		resp_paddr[0][11:0] == $past(req_vaddr[0][11:0]))
		else $error("page offset altered");
	demand_read_a: assert property (mem_rd_valid |->
		miss_phase && miss_count != 3'h0) else $error("read without miss");
	rd_hold_a: assert property (mem_rd_valid && !mem_rd_ready |=>
		mem_rd_valid && $stable(mem_rd_addr)) else $error("read dropped");
	miss_fetch_a: assert property ($rose(miss_phase) |-> ##1
		mem_rd_valid) else $error("miss not fetched");
	pulse_gap_a: assert property (resp_valid != '0 |->
		(resp_valid & $past(resp_valid)) == '0) else $error("long pulse");
	count_down_a: assert property (mem_rd_rvalid |-> ##2
		miss_count == $past(miss_count, 2) - 3'h1) else $error("no dec");
	cnt_phase_a: assert property (miss_count != 3'h0 |->
		miss_phase) else $error("count outside phase");
	phase_exit_a: assert property ($fell(miss_phase) |->
		$past(miss_count) == 3'h0) else $error("early phase exit");
	no_lookup_a: assert property (miss_phase && $past(miss_phase) |->
		resp_valid == '0) else $error("answer in miss phase");
	miss_end_a: assert property ($rose(miss_phase) |-> ##[1:400]
		!miss_phase) else $error("miss phase stuck");
	cover property (miss_count == 3'h7);
	cover property (&resp_valid);
	cover property (mem_rd_valid && !mem_rd_ready);
endmodule : atu_cache_chk
bind atu_translation_cache atu_cache_chk #(.SOURCES(SOURCES),
	.ENTRIES(ENTRIES)) atu_cache_chk_inst (.clk(clk), .nrst(nrst),
	.req_vaddr(req_vaddr), .resp_valid(resp_valid), .resp_paddr(resp_paddr),
	.mem_rd_valid(mem_rd_valid), .mem_rd_addr(mem_rd_addr),
	.mem_rd_ready(mem_rd_ready), .mem_rd_rvalid(mem_rd_rvalid),
	.miss_phase(miss_phase), .miss_count(miss_count));

// >>> testbench.sv
/*
 * self-checking bench for the translation cache with a memory model
 * assumes the model's entry encoding key 20'habcde
 */
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic slow = 1'b0;
	logic [6:0] req_valid = '0;
	logic [6:0][31:0] req_vaddr = '0;
	logic [6:0] resp_valid;
	logic [6:0][31:0] resp_paddr;
	logic [31:0] base = 32'h00010000;
	logic mem_rd_valid, mem_rd_ready, mem_rd_rvalid, miss_phase;
	logic [31:0] mem_rd_addr, mem_rd_rdata;
	logic [2:0] miss_count;
	logic [2:0] max_cnt = 3'h0;
	int err_count = 0, check_count = 0, rd_n = 0, lat = 0;
	always #20 clk = ~clk;
	// count accepted reads and the peak of pending misses
	always @(posedge clk) begin
		if (mem_rd_valid && mem_rd_ready) rd_n++;
		if (miss_count > max_cnt) max_cnt = miss_count;
	end
	atu_translation_cache atu_translation_cache_inst (.clk(clk),
		.nrst(nrst), .req_valid(req_valid), .req_vaddr(req_vaddr),
		.resp_valid(resp_valid), .resp_paddr(resp_paddr),
		.table_base(base), .mem_rd_valid(mem_rd_valid),
		.mem_rd_addr(mem_rd_addr), .mem_rd_ready(mem_rd_ready),
		.mem_rd_rvalid(mem_rd_rvalid), .mem_rd_rdata(mem_rd_rdata),
		.miss_phase(miss_phase), .miss_count(miss_count));
	atu_mem_model atu_mem_model_inst (.clk(clk), .slow(slow),
		.table_base(base), .mem_rd_valid(mem_rd_valid),
		.mem_rd_addr(mem_rd_addr), .mem_rd_ready(mem_rd_ready),
		.mem_rd_rvalid(mem_rd_rvalid), .mem_rd_rdata(mem_rd_rdata));
	task print_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// each masked source asks page vp+i; bounded wait for every answer
	task go(input logic [6:0] m, input logic [19:0] vp);
		logic [6:0] left;
		int i, n;
		@(negedge clk);
		left = m;
		lat = 0;
		for (i = 0; i < 7; i++) req_vaddr[i] = {vp + 20'(i), 12'h5a0 ^ 12'(i)};
		req_valid = m;
		for (n = 0; n < 600 && left != '0; n++) begin
			@(negedge clk);
			lat++;
			for (i = 0; i < 7; i++) begin
				if (left[i] && resp_valid[i] === 1'b1) begin
					chk(resp_paddr[i], {(vp + 20'(i)) ^ 20'habcde,
						req_vaddr[i][11:0]});
					left[i] = 1'b0;
					req_valid[i] = 1'b0;
				end
			end
		end
		if (left != '0) begin
			err_count++;
			print_verdict;
		end
	endtask : go
	task t_reset;
		chk({resp_valid, miss_phase, miss_count, mem_rd_valid}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task t_miss_hit;
		int n0;
		n0 = rd_n;
		go(7'h01, 20'h00100);
		chk(rd_n - n0, 32'h1);
		go(7'h01, 20'h00100);
		chk(rd_n - n0, 32'h1);
		chk(lat, 32'h1);
		$display("test miss_hit done");
	endtask : t_miss_hit
	// seven misses at once with slow memory, then seven hits at once
	task t_all;
		int n0;
		n0 = rd_n;
		slow = 1'b1;
		go(7'h7f, 20'h00200);
		chk(rd_n - n0, 32'h7);
		chk(max_cnt, 32'h7);
		slow = 1'b0;
		go(7'h7f, 20'h00200);
		chk(rd_n - n0, 32'h7);
		chk(lat, 32'h1);
		$display("test all done");
	endtask : t_all
	// cache is full: refreshed page must survive the next fill
	task t_lru;
		int n0;
		n0 = rd_n;
		go(7'h01, 20'h00100);
		go(7'h01, 20'h00300);
		go(7'h01, 20'h00100);
		chk(rd_n - n0, 32'h1);
		$display("test lru done");
	endtask : t_lru
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1; // all sources idle while the cache empties
		t_reset;
		t_miss_hit;
		t_all;
		t_lru;
		print_verdict;
	end
endmodule : testbench
